// >>> pkg/pump_refill_regs.vh
// Register offsets, field layouts, reset values and timing counts of the
// pump refill parameter block. Included by the design files, defines only.
`ifndef PUMP_REFILL_REGS_VH
`define PUMP_REFILL_REGS_VH

// Byte offsets on the AHB-Lite bus, one aligned word each
`define RF_OFF_CTRL        8'h00
`define RF_OFF_AMOUNT      8'h04
`define RF_OFF_PORT        8'h08
`define RF_OFF_DELAY       8'h0c
`define RF_OFF_VELOCITY    8'h10
`define RF_OFF_STATUS      8'h14

// Control field
`define RF_CTRL_INITIATE   0
// Status fields
`define RF_ST_ARMED        0
`define RF_ST_MOVING       1
`define RF_ST_DELAYING     2
`define RF_ST_REJECT       3
`define RF_ST_READY        4
`define RF_ST_SPEED_LSB    16

// Reset values
`define RF_RST_INITIATE    1'b0
`define RF_RST_AMOUNT      16'h0000
`define RF_RST_PORT        4'h2
`define RF_RST_DELAY       16'h0000
`define RF_RST_VELOCITY    16'h130e

// Ranges
`define RF_AMOUNT_MAX      16'hbb80
`define RF_PORT_MIN        4'h1
`define RF_PORT_COUNT      4'h4

// Timing: 200 MHz clock, delay counted in milliseconds
`define RF_CLK_HZ          28'hbebc200
`define RF_MS_NS           1000000
`define RF_CLK_NS          5
`define RF_MS_CYCLES       18'h30d40
`define RF_RAMP_INC        16'h0010
`define RF_RAMP_SHIFT      4

`endif

// >>> hw/refill_motion.v
// Step generator with a trapezoid speed profile for one refill movement.
// Assumes one 200 MHz clock; i_start is a one-cycle pulse while idle.
`timescale 1ns/10ps
`include "pump_refill_regs.vh"

module refill_motion (
  input  wire        i_clk,     // System clock
  input  wire        i_rst_n,   // Async reset, active low
  input  wire        i_start,   // Start pulse
  input  wire [15:0] i_steps,   // Steps to move, above zero
  input  wire [15:0] i_peak,    // Peak speed, steps per second
  output reg         o_step,    // One-cycle step pulse
  output reg         o_busy,    // Movement in progress
  output reg  [15:0] o_speed    // Present speed, steps per second
);

  reg  [27:0] acc;
  reg  [15:0] remaining;
  wire [27:0] acc_sum  = acc + {12'h000, o_speed};
  wire        step_due = o_busy && (acc_sum >= `RF_CLK_HZ);
  // Steps still needed to stop from the present speed
  wire [15:0] stop_need = o_speed >> `RF_RAMP_SHIFT;
  wire [16:0] speed_up  = {1'b0, o_speed} + {1'b0, `RF_RAMP_INC};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc       <= 28'h0000000;
      remaining <= 16'h0000;
      o_step    <= 1'b0;
      o_busy    <= 1'b0;
      o_speed   <= 16'h0000;
    end else begin
      o_step <= step_due;
      if (i_start && !o_busy) begin
        acc       <= 28'h0000000;
        remaining <= i_steps;
        o_busy    <= (i_steps != 16'h0000);
        o_speed   <= (i_peak < `RF_RAMP_INC) ? i_peak : `RF_RAMP_INC;
      end else if (step_due) begin
        acc       <= acc_sum - `RF_CLK_HZ;
        remaining <= remaining - 16'h0001;
        if (remaining == 16'h0001) begin
          o_busy  <= 1'b0;
          o_speed <= 16'h0000;
        end else if (remaining <= stop_need) begin
          if (o_speed > (`RF_RAMP_INC << 1))
            o_speed <= o_speed - `RF_RAMP_INC;
          else
            o_speed <= `RF_RAMP_INC;
        end else if (o_speed < i_peak) begin
          o_speed <= (speed_up > {1'b0, i_peak}) ? i_peak : speed_up[15:0];
        end
      end else if (o_busy) begin
        acc <= acc_sum;
      end
    end
  end

endmodule

// >>> hw/pump_refill_parameter_control.v
// Refill parameter registers of a metering pump behind an AHB-Lite slave,
// plus the sequencer that runs a refill movement and the delay after it.
// Assumes a single master, zero-wait transfers and a 200 MHz clock.
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "pump_refill_regs.vh"

module pump_refill_parameter_control #(
  parameter [17:0] MS_CYCLES = `RF_MS_CYCLES
) (
  input  wire        i_clk,       // System clock, 200 MHz
  input  wire        i_rst_n,     // Async reset, active low
  input  wire        i_hsel,      // AHB slave select
  input  wire [31:0] i_haddr,     // AHB address
  input  wire [1:0]  i_htrans,    // AHB transfer type
  input  wire        i_hwrite,    // AHB write
  input  wire [2:0]  i_hsize,     // AHB size, word only
  input  wire [31:0] i_hwdata,    // AHB write data
  input  wire        i_hready,    // AHB bus ready
  output reg  [31:0] o_hrdata,    // AHB read data
  output reg         o_hreadyout, // AHB slave ready
  output reg         o_hresp,     // AHB response, always OKAY
  input  wire        i_pump_ready,// Pump ready pin, asynchronous
  output reg  [3:0]  o_port_sel,  // Selected refill port
  output wire        o_step,      // Motor step pulse
  output reg         o_refilling  // Refill movement running
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_START = 2'b01;
  localparam [1:0] ST_MOVE  = 2'b10;
  localparam [1:0] ST_DELAY = 2'b11;

  // Parameter registers
  reg        refill_initiate;
  reg [15:0] refill_amount;
  reg [3:0]  refill_port;
  reg [15:0] refill_delay;
  reg [15:0] refill_velocity;
  reg        reject;

  // Data phase capture
  reg        wr_pend;
  reg [7:0]  wr_addr;

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg [15:0] ms_left;
  reg [17:0] cyc_cnt;
  reg        start_pulse;
  reg [2:0]  rdy_sync;
  reg        pump_ready;

  wire        mv_busy;
  wire [15:0] mv_speed;

  // Value accepted for a given offset
  function in_range;
    input [7:0]  off;
    input [31:0] val;
    begin
      case (off)
        `RF_OFF_CTRL:     in_range = (val[31:1] == 31'h00000000);
        `RF_OFF_AMOUNT:   in_range = (val <= {16'h0000, `RF_AMOUNT_MAX});
        `RF_OFF_PORT:     in_range = (val > {28'h0000000, `RF_PORT_MIN}) &&
                                     (val <= {28'h0000000, `RF_PORT_COUNT});
        `RF_OFF_DELAY:    in_range = (val[31:16] == 16'h0000);
        `RF_OFF_VELOCITY: in_range = (val[31:16] == 16'h0000) &&
                                     (val[15:0] != 16'h0000);
        default:          in_range = 1'b0;
      endcase
    end
  endfunction

  // Register read mux, used for the read data path
  function [31:0] read_word;
    input [7:0] off;
    begin
      case (off)
        `RF_OFF_CTRL:     read_word = {31'h00000000, refill_initiate};
        `RF_OFF_AMOUNT:   read_word = {16'h0000, refill_amount};
        `RF_OFF_PORT:     read_word = {28'h0000000, refill_port};
        `RF_OFF_DELAY:    read_word = {16'h0000, refill_delay};
        `RF_OFF_VELOCITY: read_word = {16'h0000, refill_velocity};
        `RF_OFF_STATUS:   read_word = {mv_speed, 11'h000, pump_ready,
                                       reject, state == ST_DELAY,
                                       mv_busy, refill_initiate};
        default:          read_word = 32'h00000000;
      endcase
    end
  endfunction

  wire addr_phase = i_hsel && i_hready && i_htrans[1];
  wire wr_ok      = wr_pend && in_range(wr_addr, i_hwdata);
  wire refill_end = (state == ST_DELAY) && (ms_left == 16'h0000);

  // Three-stage input sync; a change counts when stages two and three agree
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_sync   <= 3'b000;
      pump_ready <= 1'b0;
    end else begin
      rdy_sync <= {rdy_sync[1:0], i_pump_ready};
      if (rdy_sync[1] == rdy_sync[2])
        pump_ready <= rdy_sync[2];
    end
  end

  // AHB-Lite slave, never inserts wait states
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend     <= addr_phase && i_hwrite;
      wr_addr     <= {i_haddr[7:2], 2'b00};
      if (addr_phase && !i_hwrite)
        o_hrdata <= read_word({i_haddr[7:2], 2'b00});
    end
  end

  // Parameter storage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refill_initiate <= `RF_RST_INITIATE;
      refill_amount   <= `RF_RST_AMOUNT;
      refill_port     <= `RF_RST_PORT;
      refill_delay    <= `RF_RST_DELAY;
      refill_velocity <= `RF_RST_VELOCITY;
      reject          <= 1'b0;
    end else begin
      if (wr_pend && wr_addr != `RF_OFF_STATUS)
        reject <= !wr_ok;
      if (wr_ok) begin
        case (wr_addr)
          `RF_OFF_CTRL:     refill_initiate <= i_hwdata[`RF_CTRL_INITIATE];
          `RF_OFF_AMOUNT:   refill_amount   <= i_hwdata[15:0];
          `RF_OFF_PORT:     refill_port     <= i_hwdata[3:0];
          `RF_OFF_DELAY:    refill_delay    <= i_hwdata[15:0];
          `RF_OFF_VELOCITY: refill_velocity <= i_hwdata[15:0];
          default:          refill_initiate <= refill_initiate;
        endcase
      end
      if (refill_end && !(wr_ok && wr_addr == `RF_OFF_CTRL))
        refill_initiate <= 1'b0;
    end
  end

  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (refill_initiate && pump_ready && refill_amount != 16'h0000)
          next_state = ST_START;
      end
      ST_START: next_state = ST_MOVE;
      ST_MOVE: begin
        if (!mv_busy)
          next_state = ST_DELAY;
      end
      ST_DELAY: begin
        if (ms_left == 16'h0000)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state       <= ST_IDLE;
      ms_left     <= 16'h0000;
      cyc_cnt     <= 18'h00000;
      start_pulse <= 1'b0;
      o_port_sel  <= `RF_RST_PORT;
      o_refilling <= 1'b0;
    end else begin
      state       <= next_state;
      start_pulse <= (next_state == ST_START) && (state == ST_IDLE);
      o_refilling <= (next_state == ST_START) || (next_state == ST_MOVE);
      if (state == ST_IDLE)
        o_port_sel <= refill_port;
      if (state == ST_MOVE) begin
        ms_left <= refill_delay;
        cyc_cnt <= 18'h00000;
      end else if (state == ST_DELAY && ms_left != 16'h0000) begin
        if (cyc_cnt == MS_CYCLES - 18'h00001) begin
          cyc_cnt <= 18'h00000;
          ms_left <= ms_left - 16'h0001;
        end else begin
          cyc_cnt <= cyc_cnt + 18'h00001;
        end
      end
    end
  end

  refill_motion u_motion (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (start_pulse),
    .i_steps (refill_amount),
    .i_peak  (refill_velocity),
    .o_step  (o_step),
    .o_busy  (mv_busy),
    .o_speed (mv_speed)
  );

endmodule

// >>> verif/refill_chk.sv
// Assertion checker for the refill block, watching its ports only.
// Assumes one AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/10ps
module refill_chk #(
  parameter [17:0] MS_CYCLES = 18'h30d40
) (
  input wire        i_clk,        // Clock
  input wire        i_rst_n,      // Reset
  input wire        i_hsel,       // Select
  input wire [31:0] i_haddr,      // Address
  input wire [1:0]  i_htrans,     // Transfer
  input wire        i_hwrite,     // Write
  input wire        i_hready,     // Ready in
  input wire [31:0] o_hrdata,     // Read data
  input wire        o_hreadyout,  // Ready out
  input wire        o_hresp,      // Response
  input wire        i_pump_ready, // Pump ready
  input wire [3:0]  o_port_sel,   // Port
  input wire        o_step,       // Step
  input wire        o_refilling   // Refilling
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Read address phase at one word index
  sequence rd_at(logic [5:0] idx);
    i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[7:2] == idx;
  endsequence
  // The synchroniser needs the pin high four or five edges before start
  sequence ready_seen;
    $past(i_pump_ready, 4) || $past(i_pump_ready, 5);
  endsequence
  sequence refill_begin;
    $rose(o_refilling);
  endsequence
  a_ready_high: assert property (o_hreadyout)
    else $error("slave stalled");
  a_resp_okay: assert property (!o_hresp)
    else $error("error response");
  a_amount_max: assert property (
      rd_at(6'h01) |=> o_hrdata <= 32'h0000bb80)
    else $error("amount above limit");
  a_port_read: assert property (
      rd_at(6'h02) |=> o_hrdata > 32'h1 && o_hrdata <= 32'h4)
    else $error("port read out of range");
  a_vel_read: assert property (
      rd_at(6'h04) |=> o_hrdata != 32'h0 && o_hrdata < 32'h10000)
    else $error("velocity read bad");
  a_unmapped_zero: assert property (
      rd_at(6'h06) |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_port_pins: assert property (
      o_port_sel > 4'h1 && o_port_sel <= 4'h4)
    else $error("port pins out of range");
  a_port_held: assert property (
      o_refilling && $past(o_refilling) |-> $stable(o_port_sel))
    else $error("port moved in refill");
  a_start_ready: assert property (
      refill_begin |-> ready_seen)
    else $error("refill without ready");
  a_step_pulse: assert property (o_step |=> !o_step)
    else $error("step longer than a cycle");
  a_step_inside: assert property (
      o_step |-> o_refilling || $past(o_refilling))
    else $error("step outside refill");
endmodule

bind pump_refill_parameter_control refill_chk #(
  .MS_CYCLES (MS_CYCLES)
) refill_chk_inst (
  .i_clk        (i_clk),
  .i_rst_n      (i_rst_n),
  .i_hsel       (i_hsel),
  .i_haddr      (i_haddr),
  .i_htrans     (i_htrans),
  .i_hwrite     (i_hwrite),
  .i_hready     (i_hready),
  .o_hrdata     (o_hrdata),
  .o_hreadyout  (o_hreadyout),
  .o_hresp      (o_hresp),
  .i_pump_ready (i_pump_ready),
  .o_port_sel   (o_port_sel),
  .o_step       (o_step),
  .o_refilling  (o_refilling)
);

// >>> verif/pump_side_model.sv
// Pump side: offers the ready level and counts motor steps.
// Assumes the bench opens or closes readiness through i_allow.
`timescale 1ns/10ps
module pump_side_model (
  input  wire         i_clk,   // Clock
  input  wire         i_rst_n, // Reset
  input  wire         i_allow, // Pump may report ready
  input  wire         i_step,  // Step pulse from block
  output logic        o_ready, // Ready level
  output logic [15:0] o_steps  // Steps seen
);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_steps <= 16'h0000;
    end else begin
      o_ready <= i_allow;
      if (i_step) o_steps <= o_steps + 16'h0001;
    end
  end
endmodule

// >>> verif/pump_refill_parameter_control_tb_top.sv
// Self-checking bench for the refill block over AHB-Lite.
// Assumes zero-wait slave; a full refill is far too slow to run here.
`timescale 1ns/10ps
module pump_refill_parameter_control_tb_top;
  logic        i_clk = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0, allow = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0, q;
  logic [1:0]  i_htrans = 0;
  logic [2:0]  i_hsize = 3'h2;
  wire  [31:0] o_hrdata;
  wire         o_hreadyout, o_hresp, o_step, o_refilling, pump_ready;
  wire  [3:0]  o_port_sel;
  wire  [15:0] steps;
  int          fails = 0, compares = 0;
  always #2.5 i_clk = ~i_clk;
  pump_refill_parameter_control #(.MS_CYCLES(18'd10))
    pump_refill_parameter_control_inst (.*, .i_hready(o_hreadyout),
    .i_pump_ready(pump_ready));
  pump_side_model pump_side_model_inst (.i_clk, .i_rst_n, .i_allow(allow),
    .i_step(o_step), .o_ready(pump_ready), .o_steps(steps));
  task check(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    i_hsel   <= 1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel   <= 0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(q, exp);
    check(32'(o_hresp), 32'h0);
  endtask
  task t_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h2);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'd4878);
    rd(8'h18, 32'h0);
  endtask
  task t_amount;
    wr(8'h04, 32'd48000);
    rd(8'h04, 32'd48000);
    wr(8'h04, 32'd48001);
    rd(8'h04, 32'd48000);
    bus(8'h14, 1'b0, 32'h0);
    check(32'(q[3]), 32'h1);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h0);
    bus(8'h14, 1'b0, 32'h0);
    check(32'(q[3]), 32'h0);
  endtask
  task t_port;
    logic [31:0] pv[5] = '{0, 1, 5, 3, 4};
    logic [31:0] pe[5] = '{2, 2, 2, 3, 4};
    for (int i = 0; i < 5; i++) begin
      wr(8'h08, pv[i]);
      rd(8'h08, pe[i]);
    end
    idle(2);
    check(32'(o_port_sel), 32'h4);
  endtask
  task t_vel;
    wr(8'h10, 32'h0);
    rd(8'h10, 32'd4878);
    wr(8'h10, 32'd15000);
    rd(8'h10, 32'd15000);
    wr(8'h0c, 32'h10000);
    rd(8'h0c, 32'h0);
    wr(8'h0c, 32'h7);
    rd(8'h0c, 32'h7);
  endtask
  task t_arm;
    int n;
    allow <= 1;
    idle(8);
    wr(8'h00, 32'h1);
    idle(20);
    check(32'(o_refilling), 32'h0);
    rd(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    allow <= 0;
    wr(8'h04, 32'h5);
    idle(8);
    wr(8'h00, 32'h1);
    idle(20);
    check(32'(o_refilling), 32'h0);
    allow <= 1;
    n = 0;
    while (o_refilling !== 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    check(32'(o_refilling), 32'h1);
    wr(8'h08, 32'h3);
    idle(2);
    check(32'(o_port_sel), 32'h4);
    bus(8'h14, 1'b0, 32'h0);
    check(32'(q[31:16]), 32'd16);
    check(32'(q[1]), 32'h1);
    check(32'(q[0]), 32'h1);
    check(32'(q[4]), 32'h1);
    check(32'(q[2]), 32'h0);
    check(32'(steps), 32'h0);
  endtask
  task report_and_stop;
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Roughly sixty times the expected run length
  initial begin
    #50000;
    fails++;
    report_and_stop;
  end
  initial begin
    idle(12);
    i_rst_n <= 1;
    idle(1);
    t_reset;
    t_amount;
    t_port;
    t_vel;
    t_arm;
    report_and_stop;
  end
endmodule
